// *** design/cci_defs.vh ***
// Register map, field positions and codes of the channel 1 input conditioning block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CCI_DEFS_VH
`define CCI_DEFS_VH

// ********************************
// Register byte offsets
// ********************************
`define CCI_OFS_CONTROL 12'h010
`define CCI_OFS_CONFIG 12'h024
`define CCI_OFS_STATUS 12'h034

// ********************************
// Reset values and masks
// ********************************
`define CCI_CONFIG_RESET 32'h00000000
`define CCI_CONFIG_MASK 32'h000F000F
`define CCI_CONTROL_RESET 1'h0

// ********************************
// Field positions
// ********************************
`define CCI_ENABLE_BIT 0
`define CCI_PSC_MSB 19
`define CCI_PSC_LSB 18
`define CCI_CCS_MSB 17
`define CCI_CCS_LSB 16
`define CCI_FLT_MSB 3
`define CCI_FLT_LSB 0
`define CCI_ST_FILTERED 0
`define CCI_ST_SELECTED 1
`define CCI_ST_CNT_MSB 4
`define CCI_ST_CNT_LSB 2
`define CCI_ST_CAPTURE 5

// ********************************
// Direction selection codes
// ********************************
`define CCI_CCS_OUTPUT 2'h0
`define CCI_CCS_OWN 2'h1
`define CCI_CCS_NEIGHBOUR 2'h2
`define CCI_CCS_TRIGGER 2'h3

// ********************************
// Filter codes
// ********************************
`define CCI_FLT_NONE 4'h0
`define CCI_FLT_LAST_CLKIN 4'h3

`endif

// *** design/cci_filter.v ***
// N-event digital filter for one timer input.
// Assumes sampleIn is already synchronised to ref_clk and sampleTick is a one-cycle pulse or held high to sample every clock.
module cci_filter #(
	parameter CNT_WIDTH = 4
) (
	input wire ref_clk, // System clock
	input wire rstn, // Asynchronous reset, active low
	input wire sampleIn, // Synchronised input level
	input wire sampleTick, // Sample strobe
	input wire [CNT_WIDTH-1:0] eventCount, // Agreeing samples needed, at least 1
	output reg filtered // Filtered level
);

	reg [CNT_WIDTH-1:0] agreeCount;
	wire [CNT_WIDTH-1:0] next_agreeCount;

	assign next_agreeCount = agreeCount + {{(CNT_WIDTH-1){1'b0}}, 1'b1};

	// ********************************
	// Agreement counter
	// ********************************
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			agreeCount <= {CNT_WIDTH{1'b0}};
			filtered <= 1'b0;
		end else if (sampleTick) begin
			if (sampleIn == filtered) begin
				agreeCount <= {CNT_WIDTH{1'b0}};
			end else if (next_agreeCount >= eventCount) begin
				// Level flips only after N agreeing samples
				filtered <= sampleIn;
				agreeCount <= {CNT_WIDTH{1'b0}};
			end else begin
				agreeCount <= next_agreeCount;
			end
		end
	end

endmodule // cci_filter

// *** design/cci_top.v ***
// Channel 1 input conditioning: configuration register, input filter,
// source selection and capture event prescaler, reached over APB.
// Assumes neighbourFiltered, triggerEdgeSignal, clockInputTick and deadTimeTick
// come from logic on ref_clk; ownTimerInput is an asynchronous pin.
// Assumes an APB master that holds each request until pready is high.
//
// Chosen here: the APB interface to the registers.
`include "cci_defs.vh"

module cci_top #(
	parameter ADDR_WIDTH = 12,
	parameter DIV_WIDTH = 5,
	parameter CNT_WIDTH = 4
) (
	input wire ref_clk, // System clock, 40 MHz
	input wire rstn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB write
	input wire [ADDR_WIDTH-1:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire ownTimerInput, // Channel 1 timer input pin
	input wire neighbourFiltered, // Channel 0 filtered timer input
	input wire triggerEdgeSignal, // Trigger controller edge pulse
	input wire clockInputTick, // One pulse per clock-input period
	input wire deadTimeTick, // One pulse per dead-time sample period
	output reg captureEvent, // Prescaled capture event pulse
	output reg captureMode, // Channel is an enabled capture input
	output reg compareMode, // Channel is a compare output
	output reg channelEnable, // Channel 1 enable as held
	output reg filteredLevel // Filtered own timer input
);

	// ********************************
	// Field reset values
	// ********************************
	localparam [31:0] CONFIG_RESET = `CCI_CONFIG_RESET;
	localparam [1:0] PSC_RESET = CONFIG_RESET[`CCI_PSC_MSB:`CCI_PSC_LSB];
	localparam [1:0] CCS_RESET = CONFIG_RESET[`CCI_CCS_MSB:`CCI_CCS_LSB];
	localparam [3:0] FLT_RESET = CONFIG_RESET[`CCI_FLT_MSB:`CCI_FLT_LSB];

	// ********************************
	// Functions
	// ********************************
	// Agreeing samples needed for each filter code
	function [CNT_WIDTH-1:0] filterEvents;
		input [3:0] code;
		begin
			case (code)
				4'h0: filterEvents = 4'h1;
				4'h1: filterEvents = 4'h2;
				4'h2: filterEvents = 4'h4;
				4'h3: filterEvents = 4'h8;
				4'h4: filterEvents = 4'h6;
				4'h5: filterEvents = 4'h8;
				4'h6: filterEvents = 4'h6;
				4'h7: filterEvents = 4'h8;
				4'h8: filterEvents = 4'h6;
				4'h9: filterEvents = 4'h8;
				4'hA: filterEvents = 4'h5;
				4'hB: filterEvents = 4'h6;
				4'hC: filterEvents = 4'h8;
				4'hD: filterEvents = 4'h5;
				4'hE: filterEvents = 4'h6;
				default: filterEvents = 4'h8;
			endcase
		end
	endfunction

	// Divisor minus one for the dead-time based codes
	function [DIV_WIDTH-1:0] divTop;
		input [3:0] code;
		begin
			case (code)
				4'h4, 4'h5: divTop = 5'h01;
				4'h6, 4'h7: divTop = 5'h03;
				4'h8, 4'h9: divTop = 5'h07;
				4'hA, 4'hB, 4'hC: divTop = 5'h0F;
				4'hD, 4'hE, 4'hF: divTop = 5'h1F;
				default: divTop = 5'h00;
			endcase
		end
	endfunction

	// Events per passed event, minus one
	function [2:0] pscTop;
		input [1:0] code;
		begin
			case (code)
				2'h0: pscTop = 3'h0;
				2'h1: pscTop = 3'h1;
				2'h2: pscTop = 3'h3;
				default: pscTop = 3'h7;
			endcase
		end
	endfunction

	// ********************************
	// Declarations
	// ********************************
	reg [1:0] pscField;
	reg [1:0] ccsField;
	reg [3:0] fltField;
	reg ownSync1;
	reg ownSync2;
	reg [DIV_WIDTH-1:0] dtsDivCount;
	reg dtsDivTick;
	reg sampleTick;
	reg selectedLevel;
	reg selectedPrev;
	reg [2:0] pscCount;
	reg [31:0] next_prdata;
	reg next_pslverr;
	wire filteredOwn;
	wire [31:0] configWord;
	wire [31:0] statusWord;
	wire setupRead;
	wire accessDone;
	wire captureActive;
	wire rawEvent;
	wire writeConfig;
	wire writeControl;

	// ********************************
	// APB slave
	// ********************************
	// No wait state: data is prepared in the setup cycle, so prdata is a flop
	assign setupRead = psel & ~penable;
	assign accessDone = psel & penable & pready;
	assign writeConfig = accessDone & pwrite & (paddr == `CCI_OFS_CONFIG);
	assign writeControl = accessDone & pwrite & (paddr == `CCI_OFS_CONTROL);

	// Only the three fields are stored; every other bit reads zero
	assign configWord = {12'h000, pscField, ccsField, 12'h000, fltField};

	assign statusWord = {26'h0000000, captureMode, pscCount, selectedLevel, filteredOwn};

	always @* begin
		next_prdata = 32'h00000000;
		next_pslverr = 1'b0;
		case (paddr)
			`CCI_OFS_CONFIG: begin
				next_prdata = configWord;
			end
			`CCI_OFS_CONTROL: begin
				next_prdata = {31'h00000000, channelEnable};
			end
			`CCI_OFS_STATUS: begin
				next_prdata = statusWord;
			end
			default: begin
				next_pslverr = 1'b1;
			end
		endcase
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setupRead;
			pslverr <= setupRead & next_pslverr;
			if (setupRead && !pwrite) begin
				prdata <= next_prdata;
			end else if (accessDone) begin
				// Cleared after the access so stale data never looks valid
				prdata <= 32'h00000000;
			end
		end
	end

	// ********************************
	// Registers
	// ********************************
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pscField <= PSC_RESET;
			ccsField <= CCS_RESET;
			fltField <= FLT_RESET;
			channelEnable <= `CCI_CONTROL_RESET;
		end else begin
			if (writeConfig) begin
				pscField <= pwdata[`CCI_PSC_MSB:`CCI_PSC_LSB];
				fltField <= pwdata[`CCI_FLT_MSB:`CCI_FLT_LSB];
				// Changing the source of a running capture would fake edges
				if (!channelEnable) begin
					ccsField <= pwdata[`CCI_CCS_MSB:`CCI_CCS_LSB];
				end
			end
			// Enable lives at its own offset; only bit 0 is stored
			if (writeControl) begin
				channelEnable <= pwdata[`CCI_ENABLE_BIT];
			end
		end
	end

	// ********************************
	// Input synchroniser
	// ********************************
	// Two flops keep a metastable pin level away from the filter
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ownSync1 <= 1'b0;
			ownSync2 <= 1'b0;
		end else begin
			ownSync1 <= ownTimerInput;
			ownSync2 <= ownSync1;
		end
	end

	// ********************************
	// Sample clock
	// ********************************
	// Divider compares with >= so a smaller new divisor never stalls it
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dtsDivCount <= 5'h00;
			dtsDivTick <= 1'b0;
		end else begin
			dtsDivTick <= 1'b0;
			if (deadTimeTick) begin
				if (dtsDivCount >= divTop(fltField)) begin
					dtsDivCount <= 5'h00;
					dtsDivTick <= 1'b1;
				end else begin
					dtsDivCount <= dtsDivCount + 5'h01;
				end
			end
		end
	end

	// Sample strobe source follows the filter code
	always @* begin
		if (fltField == `CCI_FLT_NONE) begin
			sampleTick = 1'b1;
		end else if (fltField <= `CCI_FLT_LAST_CLKIN) begin
			sampleTick = clockInputTick;
		end else begin
			sampleTick = dtsDivTick;
		end
	end

	// ********************************
	// Input filter
	// ********************************
	// Filter runs in every mode so the status word always shows the pin
	cci_filter #(
		.CNT_WIDTH(CNT_WIDTH)
	) u_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.sampleIn(ownSync2),
		.sampleTick(sampleTick),
		.eventCount(filterEvents(fltField)),
		.filtered(filteredOwn)
	);

	// ********************************
	// Source selection
	// ********************************
	always @* begin
		case (ccsField)
			`CCI_CCS_OWN: selectedLevel = filteredOwn;
			`CCI_CCS_NEIGHBOUR: selectedLevel = neighbourFiltered;
			default: selectedLevel = 1'b0;
		endcase
	end

	// Capture path runs only while enabled and not in output mode
	assign captureActive = channelEnable & (ccsField != `CCI_CCS_OUTPUT);

	// Active event is a rising edge of the chosen level or the trigger pulse
	assign rawEvent = (ccsField == `CCI_CCS_TRIGGER) ? triggerEdgeSignal :
		(selectedLevel & ~selectedPrev);

	// Resets to the idle level 0 so no false edge follows reset
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			selectedPrev <= 1'b0;
		end else begin
			selectedPrev <= selectedLevel;
		end
	end

	// ********************************
	// Capture prescaler
	// ********************************
	// Count is held at zero while disabled, so each enable starts a fresh ratio
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pscCount <= 3'h0;
			captureEvent <= 1'b0;
		end else begin
			captureEvent <= 1'b0;
			if (!channelEnable) begin
				pscCount <= 3'h0;
			end else if (captureActive && rawEvent) begin
				if (pscCount >= pscTop(pscField)) begin
					pscCount <= 3'h0;
					captureEvent <= 1'b1;
				end else begin
					pscCount <= pscCount + 3'h1;
				end
			end
		end
	end

	// ********************************
	// Mode outputs
	// ********************************
	// Registered so every port of the block comes from a flop
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			captureMode <= 1'b0;
			compareMode <= 1'b1;
			filteredLevel <= 1'b0;
		end else begin
			captureMode <= captureActive;
			compareMode <= (ccsField == `CCI_CCS_OUTPUT);
			filteredLevel <= filteredOwn;
		end
	end

endmodule // cci_top

// *** sim/cci_asserts.sv ***
// Concurrent checks on the ports of the conditioning block.
// Assumes an APB master that holds each request until pready.
module cci_asserts (
	input wire logic ref_clk, // Clock
	input wire logic rstn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Write
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic captureEvent, // Event
	input wire logic captureMode, // Capture
	input wire logic compareMode, // Compare
	input wire logic channelEnable // Enable
);
	// ****
	// Properties
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence cfg_read_s;
		pready && !pwrite && paddr == 12'h024;
	endsequence
	setup_ready_a: assert property (setup_s |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	unmapped_err_a: assert property (pready && !(paddr inside {12'h010, 12'h024, 12'h034})
		|-> pslverr && prdata == 32'h0) else $error("unmapped accepted");
	reserved_zero_a: assert property (cfg_read_s |-> (prdata & 32'hFFF0FFF0) == 32'h0)
		else $error("reserved bits set");
	mode_excl_a: assert property (captureMode |-> !compareMode)
		else $error("both modes");
	cap_mode_a: assert property (captureEvent |-> captureMode)
		else $error("event outside capture");
	cap_off_a: assert property (!channelEnable [*2] |-> !captureEvent)
		else $error("event while disabled");
	sel_lock_a: assert property (channelEnable [*2] |-> $stable(compareMode))
		else $error("selection changed");
endmodule // cci_asserts
bind cci_top cci_asserts u_chk (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.captureEvent(captureEvent),
	.captureMode(captureMode),
	.compareMode(compareMode),
	.channelEnable(channelEnable)
);

// *** sim/cci_partner.sv ***
// Model of the timer pins, channel 0 filter and trigger controller.
// Assumes tasks are called right after a rising clock edge.
module cci_partner (
	input wire logic ref_clk, // Clock
	output logic ownTimerInput, // Pin
	output logic neighbourFiltered, // Channel 0 level
	output logic triggerEdgeSignal, // Trigger pulse
	output logic clockInputTick, // Every 4 clocks
	output logic deadTimeTick // Every 2 clocks
);
	// ****
	// Sample ticks, free running
	// ****
	logic [1:0] cnt;
	initial {ownTimerInput, neighbourFiltered, triggerEdgeSignal, clockInputTick, deadTimeTick, cnt} = 0;
	always @(posedge ref_clk) begin
		cnt <= cnt + 2'h1;
		clockInputTick <= cnt == 2'h3;
		deadTimeTick <= cnt[0];
	end
	task setPin(input logic v);
		@(posedge ref_clk);
		ownTimerInput <= v;
	endtask
	task setNb(input logic v);
		@(posedge ref_clk);
		neighbourFiltered <= v;
	endtask
	task trig();
		@(posedge ref_clk);
		triggerEdgeSignal <= 1'b1;
		@(posedge ref_clk);
		triggerEdgeSignal <= 1'b0;
	endtask
endmodule // cci_partner

// *** sim/cci_top_bench.sv ***
// Self-checking bench for the channel 1 conditioning block.
// Assumes the checker is bound in and the partner drives the far side.
module cci_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, captureEvent, captureMode;
	logic compareMode, channelEnable, filteredLevel, e;
	logic ownTimerInput, neighbourFiltered, triggerEdgeSignal, clockInputTick, deadTimeTick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int error_cnt = 0, comparisons = 0, evCnt = 0, n0 = 0, i, k;
	int nTab[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
	int pTab[16] = '{1, 4, 4, 4, 4, 4, 8, 8, 16, 16, 32, 32, 32, 64, 64, 64};
	cci_top DUT (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ownTimerInput(ownTimerInput),
		.neighbourFiltered(neighbourFiltered),
		.triggerEdgeSignal(triggerEdgeSignal),
		.clockInputTick(clockInputTick),
		.deadTimeTick(deadTimeTick),
		.captureEvent(captureEvent),
		.captureMode(captureMode),
		.compareMode(compareMode),
		.channelEnable(channelEnable),
		.filteredLevel(filteredLevel)
	);
	cci_partner u_far (
		.ref_clk(ref_clk),
		.ownTimerInput(ownTimerInput),
		.neighbourFiltered(neighbourFiltered),
		.triggerEdgeSignal(triggerEdgeSignal),
		.clockInputTick(clockInputTick),
		.deadTimeTick(deadTimeTick)
	);
	// ****
	// Clock, tasks
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (captureEvent === 1'b1) evCnt <= evCnt + 1;
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulses(input int n);
		repeat (n) begin
			u_far.trig();
			repeat (3) @(posedge ref_clk);
		end
	endtask
	task evChk(input string n, input int x);
		repeat (8) @(posedge ref_clk);
		chk(n, evCnt - n0, x);
		n0 = evCnt;
	endtask
	task wt(input logic v);
		k = 0;
		while (filteredLevel !== v && k < 2000) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 2000) error_cnt++;
	endtask
	task end_of_test();
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#1500000;
		error_cnt++;
		end_of_test();
	end
	// ****
	// Tests
	// ****
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = 0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		apb(0, 12'h024, 0);
		chk("config reset", r, 0);
		chk("compare mode", compareMode, 1);
		apb(1, 12'h024, 32'hFFFFFFFF);
		apb(0, 12'h024, 0);
		chk("reserved", r, 32'h000F000F);
		apb(0, 12'h100, 0);
		chk("unmapped", e, 1);
		apb(1, 12'h010, 1);
		apb(1, 12'h024, 0);
		apb(0, 12'h024, 0);
		chk("locked select", r, 32'h00030000);
		n0 = evCnt;
		for (i = 0; i < 4; i++) begin
			apb(1, 12'h024, i << 18);
			pulses(8);
			evChk("prescale", 8 >> i);
		end
		pulses(4);
		apb(1, 12'h010, 0);
		apb(1, 12'h010, 1);
		pulses(4);
		evChk("restart", 0);
		pulses(4);
		evChk("after restart", 1);
		apb(1, 12'h010, 0);
		apb(1, 12'h024, 0);
		repeat (2) @(posedge ref_clk);
		chk("output", compareMode, 1);
		apb(1, 12'h010, 1);
		pulses(2);
		evChk("no capture", 0);
		apb(1, 12'h010, 0);
		apb(1, 12'h024, 32'h00010000);
		apb(1, 12'h010, 1);
		u_far.setNb(1);
		evChk("neighbour ignored", 0);
		u_far.setPin(1);
		evChk("own", 1);
		apb(0, 12'h034, 0);
		chk("status", r, 32'h00000023);
		apb(1, 12'h010, 0);
		apb(1, 12'h024, 32'h00020000);
		apb(1, 12'h010, 1);
		u_far.setPin(0);
		u_far.setPin(1);
		evChk("own ignored", 0);
		u_far.setNb(0);
		u_far.setNb(1);
		evChk("neighbour", 1);
		apb(1, 12'h010, 0);
		for (i = 0; i < 16; i++) begin
			apb(1, 12'h024, 32'h00010000 | i);
			u_far.setPin(0);
			wt(0);
			u_far.setPin(1);
			wt(1);
			chk("filter early", k >= (nTab[i] - 1) * pTab[i] + 2, 1);
			chk("filter late", k <= nTab[i] * pTab[i] + 8, 1);
		end
		apb(1, 12'h024, 3);
		u_far.setPin(0);
		wt(0);
		repeat (2) begin
			u_far.setPin(1);
			repeat (20) @(posedge ref_clk);
			u_far.setPin(0);
			repeat (4) @(posedge ref_clk);
		end
		repeat (8) @(posedge ref_clk);
		chk("glitch", filteredLevel, 0);
		end_of_test();
	end
endmodule // cci_top_bench
